// *** sptwb_pkg.sv ***
package sptwb_pkg;
  // Register offsets on the register port
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_DATA_BUF = 8'h13;
  localparam logic [7:0] ADDR_PORT_CTRL = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h8c;
  localparam logic [7:0] ADDR_PORT_STATE = 8'h94;
  localparam logic [7:0] ADDR_OWN_HI = 8'h95;
  localparam logic [7:0] ADDR_OWN_LO = 8'h96;
  // Reset values
  localparam logic [7:0] RST_PORT_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_OWN = 8'h00;
  // Field positions
  localparam int BIT_SERIAL_IRQ = 3;
  localparam int CTRL_WRITE_COLLISION_FLAG = 7;
  localparam int CTRL_OV = 6;
  localparam int CTRL_EN = 5;
  localparam int CTRL_CKP = 4;
  // Port mode select codes
  localparam logic [3:0] MODE_SLV7 = 4'h6;
  localparam logic [3:0] MODE_SLV10 = 4'h7;
  localparam logic [3:0] MODE_MASTER_FW = 4'hb;
  localparam logic [3:0] MODE_SLV7_SP = 4'he;
  localparam logic [3:0] MODE_SLV10_SP = 4'hf;
  // Leading marker of a 10-bit address
  localparam logic [4:0] TEN_BIT_MARK = 5'h1e;
  // Timing of the host end
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BIT_RATE_KBPS = 100;
  localparam int unsigned BIT_PERIOD_NS = 1000000 / BIT_RATE_KBPS;
  localparam logic [7:0] QUARTER_CYC =
    8'((BIT_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS));
  // Host command codes
  typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} sptwb_cmd_t;
endpackage

// *** sptwb_if.sv ***
`timescale 1ns/1ps
interface sptwb_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND of both parties, pull-ups give the high level
  assign scl = ~((host_scl_oe & ~host_scl_o) | (dev_scl_oe & ~dev_scl_o));
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host(output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
  modport device(output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// *** sptwb_sync.sv ***
`timescale 1ns/1ps
module sptwb_sync #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sptwb_sync_t;

  sptwb_sync_t r;
  sptwb_sync_t next_r;

  // Two flops; only the second stage is visible
  always_comb begin
    next_r.s1 = i_d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge i_clock) begin
    r <= next_r;
  end

  assign o_q = r.s2;
endmodule // sptwb_sync

// *** sptwb_host.sv ***
`timescale 1ns/1ps
module sptwb_host (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_cmd_valid,
  input wire sptwb_pkg::sptwb_cmd_t i_cmd,
  input wire logic [7:0] i_cmd_data,
  input wire logic i_cmd_nack,
  output logic o_cmd_ready,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_ack_seen,
  sptwb_if.host bus
);
  import sptwb_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} sptwb_hst_t;
  typedef struct packed {
    sptwb_hst_t st;
    logic [1:0] q;
    logic [7:0] cnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] rx;
    logic rd;
    logic nack;
    logic scl_low;
    logic sda_low;
    logic [7:0] rdata;
    logic ack_seen;
    logic done;
  } sptwb_host_t;

  sptwb_host_t h;
  sptwb_host_t next_h;
  logic sda_s;

  sptwb_sync #(.W(1)) u_sda_sync (
    .i_clock(i_clock),
    .i_d(bus.sda),
    .o_q(sda_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-bit sequencer; SCL is divided down from i_clock
  always_comb begin
    next_h = h;
    next_h.done = 1'b0;
    if (h.st == H_IDLE) begin
      if (i_cmd_valid) begin
        next_h.q = 2'h0;
        next_h.cnt = 8'h00;
        next_h.bitn = 4'h0;
        next_h.sh = i_cmd_data;
        next_h.rd = (i_cmd == CMD_READ);
        next_h.nack = i_cmd_nack;
        case (i_cmd)
          CMD_START: next_h.st = H_START;
          CMD_STOP: next_h.st = H_STOP;
          default: next_h.st = H_BIT;
        endcase
      end
    end else if (h.cnt == QUARTER_CYC - 8'h01) begin
      next_h.cnt = 8'h00;
      next_h.q = 2'(h.q + 2'h1);
      case (h.st)
        H_START: begin
          case (h.q)
            2'h0: next_h.sda_low = 1'b0;
            2'h1: next_h.scl_low = 1'b0;
            2'h2: next_h.sda_low = 1'b1; // Fall of SDA with SCL high
            default: begin
              next_h.scl_low = 1'b1;
              next_h.st = H_IDLE;
              next_h.done = 1'b1;
            end
          endcase
        end
        H_STOP: begin
          case (h.q)
            2'h0: begin
              next_h.scl_low = 1'b1;
              next_h.sda_low = 1'b1;
            end
            2'h1: next_h.scl_low = 1'b0;
            2'h2: next_h.sda_low = 1'b0; // Rise of SDA with SCL high
            default: begin
              next_h.st = H_IDLE;
              next_h.done = 1'b1;
            end
          endcase
        end
        H_BIT: begin
          case (h.q)
            // SDA changes only in the low half
            2'h0: begin
              if (h.bitn[3]) begin
                next_h.sda_low = h.rd & ~h.nack; // Ack all but last read
              end else begin
                next_h.sda_low = ~h.rd & ~h.sh[7];
              end
            end
            2'h1: next_h.scl_low = 1'b0; // Master clocks both ways
            2'h2: begin
              if (h.bitn[3]) begin
                next_h.ack_seen = ~sda_s; // Caller aborts on nack
              end else begin
                next_h.rx = {h.rx[6:0], sda_s};
              end
            end
            default: begin
              next_h.scl_low = 1'b1;
              if (h.bitn[3]) begin
                next_h.st = H_IDLE;
                next_h.rdata = h.rx;
                next_h.done = 1'b1;
              end else begin
                next_h.sh = {h.sh[6:0], 1'b0};
                next_h.bitn = 4'(h.bitn + 4'h1);
              end
            end
          endcase
        end
        default: next_h.st = H_IDLE;
      endcase
    end else begin
      next_h.cnt = 8'(h.cnt + 8'h01);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      h <= '0;
    end else begin
      h <= next_h;
    end
  end

  // Open-drain drive: only ever pulls low
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = h.scl_low;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = h.sda_low;
  assign o_cmd_ready = (h.st == H_IDLE);
  assign o_done = h.done;
  assign o_rdata = h.rdata;
  assign o_ack_seen = h.ack_seen;
endmodule // sptwb_host

// *** sptwb_device.sv ***
//
// Contract
// - Idle bus: both lines released high
// - Start: SDA falls while SCL high
// - Stop: SDA rises while SCL high
// - Data changes only while SCL low
// - Only the master issues start, stop
// - Master clocks both transfer directions
// - Outputs open-drain, wired-AND lines
// - Master sends address with read/write bit
// - Slave joins only on own address
// - 7-bit address plus R/W is one byte
// - 10-bit address: two bytes, 11110 marker
// - Master and slave take opposite roles
// - Whole bytes, no byte count limit
// - Receiving slave acknowledges every byte
// - Master aborts on missing acknowledge
// - Nacking slave leaves SDA released
// - Slave protocol fully in hardware
// - Standard mode up to 100 Kbps
// - Auto acknowledge then load receive buffer
// - No ack if buffer full or overflow
// - Unread buffer: set overflow, drop byte
// - Master-receiver nacks last byte, then stops
`timescale 1ns/1ps
module sptwb_device (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_link_clock,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_serial_irq,
  sptwb_if.device bus
);
  import sptwb_pkg::*;

  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_ADDR_LO, L_RX, L_TX, L_MACK} sptwb_lst_t;
  typedef struct packed {
    sptwb_lst_t st;
    sptwb_lst_t go;
    logic [3:0] cnt;
    logic ackd;
    logic [7:0] sh;
    logic sda_oe;
    logic hi_seen;
    logic scl_q;
    logic sda_q;
    logic ev_tog;
    logic [7:0] ev_data;
    logic ev_addr;
    logic ev_tx;
    logic cd_tog;
    logic p;
    logic s;
    logic rw;
  } sptwb_lk_t;
  typedef struct packed {
    logic [7:0] buffer;
    logic bf;
    logic ov;
    logic write_collision_flag;
    logic en;
    logic clock_polarity_release;
    logic [3:0] mode;
    logic irq;
    logic irq_en;
    logic [7:0] own_hi;
    logic [7:0] own_lo;
    logic da;
    logic ev_prev;
    logic ev_hit;
    logic cd_prev;
    logic cd_hit;
    logic [7:0] rdata;
  } sptwb_sy_t;

  sptwb_lk_t lk;
  sptwb_lk_t next_lk;
  sptwb_sy_t sy;
  sptwb_sy_t next_sy;
  logic lrst_n;
  logic [1:0] pin_s;
  logic [26:0] cfg_s;
  logic [14:0] up_s;
  logic scl;
  logic sda;
  logic slave_on;
  logic ten;
  logic blocked;
  logic [7:0] own_hi;
  logic [7:0] own_lo;
  logic [7:0] txd;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings; config words pass two flops and are also changed while the port is enabled
  sptwb_sync #(.W(1)) u_rst_sync (
    .i_clock(i_link_clock),
    .i_d(i_rst_n),
    .o_q(lrst_n)
  );
  sptwb_sync #(.W(2)) u_pin_sync (
    .i_clock(i_link_clock),
    .i_d({bus.scl, bus.sda}),
    .o_q(pin_s) // Two flops, still far above 100 Kbps
  );
  sptwb_sync #(.W(27)) u_cfg_sync (
    .i_clock(i_link_clock),
    .i_d({sy.en & (sy.mode[2:1] == MODE_SLV7[2:1]), sy.mode[0], sy.bf | sy.ov,
          sy.own_hi, sy.own_lo, sy.buffer}),
    .o_q(cfg_s)
  );
  sptwb_sync #(.W(15)) u_up_sync (
    .i_clock(i_clock),
    .i_d({lk.ev_tog, lk.cd_tog, lk.p, lk.s, lk.rw, lk.ev_addr, lk.ev_tx, lk.ev_data}),
    .o_q(up_s)
  );

  assign {scl, sda} = pin_s;
  assign {slave_on, ten, blocked, own_hi, own_lo, txd} = cfg_s;
  assign scl_rise = scl & ~lk.scl_q;
  assign scl_fall = ~scl & lk.scl_q;
  assign start_cond = scl & lk.scl_q & lk.sda_q & ~sda;
  assign stop_cond = scl & lk.scl_q & ~lk.sda_q & sda;

  ////////////////////////////////////////////////////////////////////////////
  // Link side: slave protocol on the link clock, no firmware help
  always_comb begin
    logic hit;
    logic ack;
    sptwb_lst_t go;
    hit = 1'b0;
    ack = 1'b0;
    go = L_IDLE;
    next_lk = lk;
    next_lk.scl_q = scl;
    next_lk.sda_q = sda;
    if (start_cond) begin
      next_lk.st = L_ADDR;
      next_lk.cnt = 4'h0;
      next_lk.ackd = 1'b0;
      next_lk.sda_oe = 1'b0;
      next_lk.s = 1'b1;
      next_lk.p = 1'b0;
      next_lk.cd_tog = ~lk.cd_tog;
    end else if (stop_cond) begin
      next_lk.st = L_IDLE;
      next_lk.ackd = 1'b0;
      next_lk.sda_oe = 1'b0;
      next_lk.hi_seen = 1'b0;
      next_lk.p = 1'b1;
      next_lk.s = 1'b0;
      next_lk.cd_tog = ~lk.cd_tog;
    end else if (lk.ackd) begin
      // Ack slot ends at the fall after the ninth rise
      if (scl_fall) begin
        next_lk.ackd = 1'b0;
        next_lk.cnt = 4'h0;
        next_lk.st = lk.go;
        next_lk.sda_oe = (lk.go == L_TX) & ~lk.sh[7];
      end
    end else begin
      case (lk.st)
        L_ADDR, L_ADDR_LO, L_RX: begin
          if (scl_rise && !lk.cnt[3]) begin
            next_lk.sh = {lk.sh[6:0], sda}; // Whole bytes, MSB first
            next_lk.cnt = 4'(lk.cnt + 4'h1);
          end else if (scl_fall && lk.cnt[3]) begin
            if (lk.st == L_ADDR) begin
              if (!ten) begin
                hit = (lk.sh[7:1] == own_hi[7:1]);
                go = lk.sh[0] ? L_TX : L_RX; // Opposite role
              end else if (lk.sh[7:3] == TEN_BIT_MARK && lk.sh[2:1] == own_hi[2:1]) begin
                hit = ~lk.sh[0] | lk.hi_seen;
                go = lk.sh[0] ? L_TX : L_ADDR_LO;
              end
              if (hit) begin
                next_lk.rw = lk.sh[0];
              end
            end else if (lk.st == L_ADDR_LO) begin
              hit = (lk.sh == own_lo);
              go = L_RX;
              next_lk.hi_seen = hit;
            end else begin
              hit = 1'b1;
              go = L_RX;
            end
            ack = hit & ~blocked;
            next_lk.ackd = hit;
            next_lk.go = ack ? go : L_IDLE;
            next_lk.sda_oe = ack; // Auto ack on every matching byte unless buffer full or overflow
            if (hit) begin
              next_lk.ev_tog = ~lk.ev_tog;
              next_lk.ev_data = lk.sh;
              next_lk.ev_addr = (lk.st != L_RX);
              next_lk.ev_tx = 1'b0;
            end
            if (ack && go == L_TX) begin
              next_lk.sh = txd;
            end
            if (!hit) begin
              next_lk.st = L_IDLE; // Not ours: stay released
            end
          end
        end
        L_TX: begin
          if (scl_rise && !lk.cnt[3]) begin
            next_lk.cnt = 4'(lk.cnt + 4'h1);
          end else if (scl_fall) begin
            if (lk.cnt[3]) begin
              next_lk.sda_oe = 1'b0;
              next_lk.st = L_MACK;
            end else begin
              next_lk.sda_oe = ~lk.sh[3'(4'h7 - lk.cnt)]; // Change in low half
            end
          end
        end
        L_MACK: begin
          if (scl_rise) begin
            next_lk.ev_tog = ~lk.ev_tog;
            next_lk.ev_tx = 1'b1;
            next_lk.ev_addr = 1'b0;
            next_lk.cnt = 4'h0;
            next_lk.sh = txd;
            next_lk.st = sda ? L_IDLE : L_TX; // Master nack ends sending
          end
        end
        default: next_lk.sda_oe = 1'b0;
      endcase
    end
    if (!slave_on) begin
      next_lk.st = L_IDLE;
      next_lk.ackd = 1'b0;
      next_lk.sda_oe = 1'b0; // Released outside transfers
    end
  end

  always_ff @(posedge i_link_clock) begin
    if (!lrst_n) begin
      lk <= '0;
      lk.scl_q <= 1'b1; // Idle level, so no false edge after reset
      lk.sda_q <= 1'b1;
    end else begin
      lk <= next_lk;
    end
  end

  // Open drain, never stretches SCL; stop stays possible on nack
  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_scl_oe = 1'b0;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = lk.sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // System side: register file, buffer and flags
  always_comb begin
    logic [7:0] rd;
    rd = 8'h00;
    next_sy = sy;
    // Data taken one cycle after the toggle, so it has settled
    next_sy.ev_prev = up_s[14];
    next_sy.ev_hit = up_s[14] ^ sy.ev_prev;
    next_sy.cd_prev = up_s[13];
    next_sy.cd_hit = up_s[13] ^ sy.cd_prev;
    case (i_reg_addr)
      ADDR_IRQ_FLAGS: rd[BIT_SERIAL_IRQ] = sy.irq;
      ADDR_IRQ_EN: rd[BIT_SERIAL_IRQ] = sy.irq_en;
      ADDR_DATA_BUF: rd = sy.buffer;
      ADDR_PORT_CTRL: rd = {sy.write_collision_flag, sy.ov, sy.en, sy.clock_polarity_release, sy.mode};
      ADDR_PORT_STATE: rd = {2'h0, sy.da, up_s[12], up_s[11], up_s[10], 1'b0, sy.bf};
      ADDR_OWN_HI: rd = sy.own_hi;
      ADDR_OWN_LO: rd = sy.own_lo;
      default: rd = 8'h00;
    endcase
    if (i_reg_rd) begin
      next_sy.rdata = rd;
      if (i_reg_addr == ADDR_DATA_BUF) begin
        next_sy.bf = 1'b0;
      end
    end
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_IRQ_FLAGS: next_sy.irq = i_reg_wdata[BIT_SERIAL_IRQ];
        ADDR_IRQ_EN: next_sy.irq_en = i_reg_wdata[BIT_SERIAL_IRQ];
        ADDR_PORT_CTRL: begin
          next_sy.write_collision_flag = i_reg_wdata[CTRL_WRITE_COLLISION_FLAG];
          next_sy.ov = i_reg_wdata[CTRL_OV];
          next_sy.en = i_reg_wdata[CTRL_EN];
          next_sy.clock_polarity_release = i_reg_wdata[CTRL_CKP];
          next_sy.mode = i_reg_wdata[3:0];
        end
        ADDR_DATA_BUF: begin
          // A write while the slave is sending would corrupt the byte
          if (up_s[10] && up_s[11]) begin
            next_sy.write_collision_flag = 1'b1;
          end else begin
            next_sy.buffer = i_reg_wdata;
          end
        end
        ADDR_OWN_HI: next_sy.own_hi = i_reg_wdata;
        ADDR_OWN_LO: next_sy.own_lo = i_reg_wdata;
        default: next_sy.rdata = sy.rdata;
      endcase
    end
    // Hardware sets come last so they win over a clear
    if (sy.ev_hit) begin
      if (up_s[8]) begin
        next_sy.irq = 1'b1;
      end else if (sy.bf) begin
        next_sy.ov = 1'b1; // Unread buffer: new byte lost
        next_sy.irq = 1'b1;
      end else begin
        next_sy.buffer = up_s[7:0];
        next_sy.bf = 1'b1;
        next_sy.da = ~up_s[9];
        next_sy.irq = 1'b1;
      end
    end
    if (sy.cd_hit && sy.mode[3] && sy.mode[2:1] == MODE_SLV7_SP[2:1]) begin
      next_sy.irq = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sy <= '0;
      sy.own_hi <= RST_OWN;
      sy.own_lo <= RST_OWN;
      {sy.write_collision_flag, sy.ov, sy.en, sy.clock_polarity_release, sy.mode} <= RST_PORT_CTRL;
      sy.irq <= RST_IRQ_FLAGS[BIT_SERIAL_IRQ];
      sy.irq_en <= RST_IRQ_EN[BIT_SERIAL_IRQ];
    end else begin
      sy <= next_sy;
    end
  end

  assign o_reg_rdata = sy.rdata;
  assign o_serial_irq = sy.irq & sy.irq_en;
endmodule // sptwb_device

// *** sptwb_checker.sv ***
`timescale 1ns/1ps
module sptwb_checker (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge i_clock); endclocking
  // Quiet until the link side has left reset as well
  logic [4:0] settle;
  default disable iff (!i_rst_n || settle != 5'h1f);
  ////////////////////////////////////////////////////////////////////////////
  // Frame tracker: start/stop, clock rises in the byte, cycles per bit
  logic prev_scl, prev_sda, busy, first_byte, seen_rise;
  logic [3:0] rises;
  logic [15:0] period;
  wire rise_c = scl && !prev_scl;
  wire start_c = scl && prev_scl && prev_sda && !sda;
  wire stop_c = scl && prev_scl && !prev_sda && sda;
  always_ff @(posedge i_clock) begin
    prev_scl <= scl;
    prev_sda <= sda;
    if (!i_rst_n) begin
      busy <= 1'b0;
      first_byte <= 1'b0;
      seen_rise <= 1'b0;
      rises <= 4'h0;
      period <= 16'h0000;
      settle <= 5'h00;
    end else begin
      settle <= (settle == 5'h1f) ? settle : settle + 5'h01;
      period <= rise_c ? 16'h0000 : (&period ? period : period + 16'h0001);
      if (rise_c) seen_rise <= 1'b1;
      if (start_c) begin
        busy <= 1'b1;
        first_byte <= 1'b1;
        rises <= 4'h0;
      end else if (stop_c) begin
        busy <= 1'b0;
      end else if (rise_c) begin
        // Ninth rise closes the byte
        rises <= (rises == 4'h8) ? 4'h0 : rises + 4'h1;
        if (rises == 4'h8) first_byte <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Wire rules
  a_open_drain: assert property (!(host_scl_oe && host_scl_o) && !(host_sda_oe && host_sda_o) && !(dev_scl_oe && dev_scl_o) && !(dev_sda_oe && dev_sda_o))
    else $error("a driver pushes a line high");
  a_idle_high: assert property ((!host_scl_oe && !host_sda_oe && !dev_scl_oe && !dev_sda_oe) |-> (scl && sda))
    else $error("released bus not high");
  a_dev_data_edge: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("slave changed data with clock high");
  a_master_cond: assert property ((scl && $past(scl) && $changed(sda)) |-> ($changed(host_sda_oe) && !dev_sda_oe))
    else $error("start or stop not made by master");
  a_master_clock: assert property ($fell(scl) |-> host_scl_oe)
    else $error("clock low not driven by master");
  a_dev_in_frame: assert property (dev_sda_oe |-> busy)
    else $error("slave drives data outside a frame");
  a_addr_by_host: assert property ((first_byte && scl && rises < 4'h8) |-> !dev_sda_oe)
    else $error("slave drives during address bits");
  a_ack_slot: assert property (($rose(dev_sda_oe) && first_byte) |-> rises == 4'h8)
    else $error("address acknowledge outside ninth bit");
  a_bit_period: assert property (($rose(scl) && seen_rise) |-> period >= 16'd999)
    else $error("bit faster than standard rate");
  a_stop_release: assert property (($rose(sda) && scl && $past(scl)) |-> (!host_sda_oe && !host_scl_oe))
    else $error("stop leaves a line driven");
  c_start: cover property (start_c);
  c_ack: cover property ($rose(dev_sda_oe));
  c_stop: cover property (stop_c);
endmodule // sptwb_checker

// *** serial_port_two_wire_bus_test.sv ***
`timescale 1ns/1ps
module serial_port_two_wire_bus_test;
  import sptwb_pkg::*;
  logic i_clock = 1'b0, link_clock = 1'b0, i_rst_n = 1'b0;
  logic cmd_valid = 1'b0, cmd_nack = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  sptwb_cmd_t cmd = CMD_START;
  logic [7:0] cmd_data = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00;
  logic cmd_ready, done, ack_seen, serial_irq;
  logic [7:0] rdata, reg_rdata, txb;
  logic [6:0] own;
  logic m_bf = 1'b0, m_ov = 1'b0;
  logic [7:0] m_buf;
  int seed, miscompares = 0, check_count = 0;
  sptwb_if bus ();
  sptwb_host sptwb_host_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .i_cmd_data(cmd_data), .i_cmd_nack(cmd_nack), .o_cmd_ready(cmd_ready),
    .o_done(done), .o_rdata(rdata), .o_ack_seen(ack_seen), .bus(bus.host));
  sptwb_device sptwb_device_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_link_clock(link_clock),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .o_serial_irq(serial_irq), .bus(bus.device));
  sptwb_checker sptwb_checker_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .host_scl_o(bus.host_scl_o), .host_scl_oe(bus.host_scl_oe), .host_sda_o(bus.host_sda_o),
    .host_sda_oe(bus.host_sda_oe), .dev_scl_o(bus.dev_scl_o), .dev_scl_oe(bus.dev_scl_oe),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
  ////////////////////////////////////////////////////////////////////////////
  // Clocks: link clock free running, phase unrelated
  initial forever #5 i_clock = ~i_clock;
  initial begin
    #3.3;
    forever #32 link_clock = ~link_clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Compares, verdict
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Register port and host command drivers
  task automatic reg_put(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge i_clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge i_clock);
    reg_rd <= 1'b0;
    @(negedge i_clock);
    check8(what, exp, reg_rdata);
  endtask
  task automatic host_cmd(input sptwb_cmd_t c, input logic [7:0] d, input logic nk);
    int n;
    @(posedge i_clock);
    cmd_valid <= 1'b1;
    cmd <= c;
    cmd_data <= d;
    cmd_nack <= nk;
    @(posedge i_clock);
    cmd_valid <= 1'b0;
    for (n = 0; n < 12000; n++) begin
      @(negedge i_clock);
      if (done === 1'b1) break;
    end
    if (n == 12000) begin
      miscompares++;
      $display("BAD host_done expected 1 seen 0");
      test_done();
    end
  endtask
  // Model: ack unless buffer full or overflow, address must match
  task automatic send(input logic [7:0] d, input logic is_addr);
    logic match, exp_ack;
    match = !is_addr || (d[7:1] === own);
    exp_ack = match && !m_bf && !m_ov;
    host_cmd(CMD_WRITE, d, 1'b0);
    check1("ack", exp_ack, ack_seen);
    if (exp_ack) begin
      m_buf = d;
      m_bf = 1'b1;
    end else if (match) begin
      m_ov = 1'b1;
    end
    // Byte events cross two system-clock flops, then a few system cycles
    repeat (40) @(posedge i_clock);
  endtask
  task automatic rd_buf();
    reg_chk("buffer", ADDR_DATA_BUF, m_buf);
    m_bf = 1'b0;
  endtask
  task automatic irq_is(input logic exp);
    @(negedge i_clock);
    check1("irq", exp, serial_irq);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'h6085;
    own = 7'h10 | 7'($random(seed) & 32'h2f);
    repeat (16) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (8) @(posedge i_clock);
    reg_chk("ctrl_rst", ADDR_PORT_CTRL, RST_PORT_CTRL);
    reg_chk("state_rst", ADDR_PORT_STATE, 8'h00);
    reg_chk("unmapped", 8'h20, 8'h00);
    reg_put(ADDR_OWN_HI, {own, 1'b0});
    reg_put(ADDR_PORT_CTRL, {4'h3, MODE_SLV7});
    reg_chk("ctrl", ADDR_PORT_CTRL, {4'h3, MODE_SLV7});
    reg_put(ADDR_IRQ_EN, 8'h08);
    $display("test setup done");
    // Slave transmits, master nacks the last byte; buffer write refused mid-transfer
    txb = 8'($random(seed));
    reg_put(ADDR_DATA_BUF, txb);
    host_cmd(CMD_START, 8'h00, 1'b0);
    send({own, 1'b1}, 1'b1);
    reg_put(ADDR_DATA_BUF, ~txb);
    reg_chk("collision", ADDR_PORT_CTRL, {4'hb, MODE_SLV7});
    host_cmd(CMD_READ, 8'h00, 1'b1);
    check8("rx_byte", txb, rdata);
    host_cmd(CMD_STOP, 8'h00, 1'b0);
    rd_buf();
    reg_put(ADDR_PORT_CTRL, {4'h3, MODE_SLV7});
    reg_put(ADDR_IRQ_FLAGS, 8'h00);
    $display("test slave transmit done");
    // Slave receives, irq cleared, raised, masked, then overflow
    host_cmd(CMD_START, 8'h00, 1'b0);
    send({own, 1'b0}, 1'b1);
    rd_buf();
    reg_put(ADDR_IRQ_FLAGS, 8'h00);
    irq_is(1'b0);
    send(8'($random(seed)), 1'b0);
    irq_is(1'b1);
    reg_chk("flags", ADDR_IRQ_FLAGS, 8'h08);
    reg_put(ADDR_IRQ_EN, 8'h00);
    irq_is(1'b0);
    reg_put(ADDR_IRQ_EN, 8'h08);
    rd_buf();
    send(8'($random(seed)), 1'b0);
    send(8'($random(seed)), 1'b0);
    host_cmd(CMD_STOP, 8'h00, 1'b0);
    reg_chk("overflow", ADDR_PORT_CTRL, {3'b011, 1'b1, MODE_SLV7});
    rd_buf();
    reg_put(ADDR_PORT_CTRL, {4'h3, MODE_SLV7});
    m_ov = 1'b0;
    $display("test slave receive done");
    // Another slave's address is ignored; start and stop still raise the flag
    reg_put(ADDR_PORT_CTRL, {4'h3, MODE_SLV7_SP});
    reg_put(ADDR_IRQ_FLAGS, 8'h00);
    host_cmd(CMD_START, 8'h00, 1'b0);
    send({own ^ 7'h01, 1'b0}, 1'b1);
    host_cmd(CMD_STOP, 8'h00, 1'b0);
    reg_chk("ctrl_after", ADDR_PORT_CTRL, {4'h3, MODE_SLV7_SP});
    reg_chk("flags_ss", ADDR_IRQ_FLAGS, 8'h08);
    reg_chk("state", ADDR_PORT_STATE, 8'h30);
    $display("test foreign address done");
    // 10-bit addressing: marker byte, buffer read, then the low byte
    own = {TEN_BIT_MARK, 2'($random(seed))};
    reg_put(ADDR_OWN_HI, {own, 1'b0});
    reg_put(ADDR_OWN_LO, txb);
    reg_put(ADDR_PORT_CTRL, {4'h3, MODE_SLV10});
    host_cmd(CMD_START, 8'h00, 1'b0);
    send({own, 1'b0}, 1'b1);
    rd_buf();
    send(txb, 1'b0);
    rd_buf();
    host_cmd(CMD_STOP, 8'h00, 1'b0);
    $display("test ten-bit address done");
    test_done();
  end
endmodule // serial_port_two_wire_bus_test
